/* File: ccd_pkg.sv */
// Package for the arithmetic and control decode block: map, flags, opcodes, timing.
// Assumes a 25 MHz aclk where one processor clock state equals one aclk cycle.
package ccd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_OPCODE   = 8'h00;
    localparam logic [7:0] OFF_FLAGS    = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_PC       = 8'h0C;
    localparam logic [7:0] OFF_WAKE     = 8'h10;
    localparam logic [7:0] OFF_REG_BASE = 8'h20;
    localparam logic [7:0] OFF_REG_LAST = 8'h3C;
    // Flag bit positions
    localparam int FLG_S  = 7;
    localparam int FLG_Z  = 6;
    localparam int FLG_H  = 4;
    localparam int FLG_PV = 2;
    localparam int FLG_N  = 1;
    localparam int FLG_C  = 0;
    // Reset values
    localparam logic [7:0]  RST_FLAGS = 8'h00;
    localparam logic [15:0] RST_PC    = 16'h0000;
    localparam logic [1:0]  RST_MODE  = 2'h0;
    // Clock states per opcode byte
    localparam logic [3:0] T_ONE_BYTE = 4'h4;
    localparam logic [3:0] T_INC_MEM  = 4'hB;
    localparam logic [3:0] T_PFX_HALF = 4'h4;
    // Opcodes
    localparam logic [7:0] OPC_IDLE     = 8'h00;
    localparam logic [7:0] OPC_DECIMAL  = 8'h27;
    localparam logic [7:0] OPC_INVERT   = 8'h2F;
    localparam logic [7:0] OPC_CSET     = 8'h37;
    localparam logic [7:0] OPC_CTOG     = 8'h3F;
    localparam logic [7:0] OPC_HALT     = 8'h76;
    localparam logic [7:0] OPC_INT_OFF  = 8'hF3;
    localparam logic [7:0] OPC_INT_ON   = 8'hFB;
    localparam logic [7:0] OPC_PREFIX   = 8'hED;
    localparam logic [7:0] OPC_TWOS     = 8'h44;
    localparam logic [7:0] OPC_MODE0    = 8'h46;
    localparam logic [7:0] OPC_MODE1    = 8'h56;
    localparam logic [7:0] OPC_MODE2    = 8'h5E;
    localparam logic [2:0] FIELD_INC    = 3'b100;
    localparam logic [2:0] FIELD_SUB1   = 3'b101;
    localparam logic [2:0] MEM_IDX      = 3'b110;
    localparam logic [2:0] ACC_IDX      = 3'b111;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {ALU_INC, ALU_SUB1, ALU_INVERT, ALU_TWOS,
                              ALU_DECIMAL, ALU_CSET, ALU_CTOG} ccd_alu_e;
    typedef enum logic [2:0] {K_ALU, K_IDLE, K_HALT, K_IOFF, K_ION,
                              K_PFX, K_MODE, K_BAD} ccd_kind_e;
    typedef enum logic [1:0] {EX_IDLE, EX_BUSY, EX_HALT} ccd_exec_e;
endpackage

/* File: ccd_alu_if.sv */
// Interface between the execute core and the accumulator/flag unit.
// Assumes ccd_pkg is compiled first.
`timescale 1ns/10ps
interface ccd_alu_if;
    ccd_pkg::ccd_alu_e op;
    logic [7:0]        a;
    logic [7:0]        fin;
    logic [7:0]        res;
    logic [7:0]        fout;
    modport alu  (input op, a, fin, output res, fout);
    modport core (output op, a, fin, input res, fout);
endinterface

/* File: ccd_alu.sv */
// Combinational result and flag unit for single-operand and accumulator ops.
// Assumes the core holds operands stable for the cycle it samples the result.
`timescale 1ns/10ps
module ccd_alu (
    ccd_alu_if.alu alu
);
    // Sign and zero from a result
    function automatic logic [7:0] set_sz(input logic [7:0] f, input logic [7:0] r);
        logic [7:0] g;
        g = f;
        g[ccd_pkg::FLG_S] = r[7];
        g[ccd_pkg::FLG_Z] = (r == 8'h00);
        return g;
    endfunction

    // Result and flag computation
    always_comb
    begin
        logic [7:0] f;
        logic [7:0] r;
        logic [7:0] adj;
        f   = alu.fin;
        r   = alu.a;
        adj = 8'h00;
        case (alu.op)
            ccd_pkg::ALU_INC:
            begin
                r = alu.a + 8'h01;
                f[ccd_pkg::FLG_H]  = (alu.a[3:0] == 4'hF);
                f[ccd_pkg::FLG_PV] = (alu.a == 8'h7F);
                f[ccd_pkg::FLG_N]  = 1'b0;
                f = set_sz(f, r);
            end
            ccd_pkg::ALU_SUB1:
            begin
                r = alu.a - 8'h01;
                f[ccd_pkg::FLG_H]  = (alu.a[3:0] == 4'h0);
                f[ccd_pkg::FLG_PV] = (alu.a == 8'h80);
                f[ccd_pkg::FLG_N]  = 1'b1;
                f = set_sz(f, r);
            end
            ccd_pkg::ALU_INVERT:
            begin
                r = ~alu.a;
                f[ccd_pkg::FLG_H] = 1'b1;
                f[ccd_pkg::FLG_N] = 1'b1;
            end
            ccd_pkg::ALU_TWOS:
            begin
                r = 8'h00 - alu.a;
                f[ccd_pkg::FLG_C]  = (alu.a != 8'h00);
                f[ccd_pkg::FLG_H]  = (alu.a[3:0] != 4'h0);
                f[ccd_pkg::FLG_PV] = (alu.a == 8'h80);
                f[ccd_pkg::FLG_N]  = 1'b1;
                f = set_sz(f, r);
            end
            ccd_pkg::ALU_DECIMAL:
            begin
                if (alu.fin[ccd_pkg::FLG_H] || (alu.a[3:0] > 4'h9))
                    adj[3:0] = 4'h6;
                if (alu.fin[ccd_pkg::FLG_C] || (alu.a > 8'h99))
                begin
                    adj[7:4] = 4'h6;
                    f[ccd_pkg::FLG_C] = 1'b1;
                end
                r = alu.fin[ccd_pkg::FLG_N] ? (alu.a - adj) : (alu.a + adj);
                f[ccd_pkg::FLG_H] = alu.fin[ccd_pkg::FLG_N]
                                  ? (alu.fin[ccd_pkg::FLG_H] && (alu.a[3:0] < 4'h6))
                                  : (alu.a[3:0] > 4'h9);
                f[ccd_pkg::FLG_PV] = ~^r;
                f = set_sz(f, r);
            end
            ccd_pkg::ALU_CSET:
            begin
                f[ccd_pkg::FLG_C] = 1'b1;
                f[ccd_pkg::FLG_H] = 1'b0;
                f[ccd_pkg::FLG_N] = 1'b0;
            end
            ccd_pkg::ALU_CTOG:
            begin
                f[ccd_pkg::FLG_H] = alu.fin[ccd_pkg::FLG_C]; // Undefined, old carry
                f[ccd_pkg::FLG_C] = ~alu.fin[ccd_pkg::FLG_C];
                f[ccd_pkg::FLG_N] = 1'b0;
            end
            default:
            begin
                r = alu.a;
            end
        endcase
        alu.res  = r;
        alu.fout = f;
    end
endmodule

/* File: ccd_core.sv */
// Decode and execute core with AXI4-Lite register access.
// Assumes one AXI4-Lite master, aclk at 25 MHz, opcode bytes written by software.
//
// Overview of operation
// - Increment, decrement and negate load the parity/overflow flag with signed overflow.
// - Decimal adjust loads the parity/overflow flag with 1 for even parity, 0 for odd.
// - Invert replaces the accumulator with its complement in 4 states, sets H and N.
// - Negate is a two-byte opcode of 8 states forming the two's complement.
// - Interrupt-off clears and interrupt-on sets the enable latch in 4 states, no flags.
// - Carry-set forces carry and clears H and N; carry-toggle inverts carry, clears N.
// - Mode select 0 is two bytes, 8 states, selects mode 0 and keeps flags.
// - Mode select 1 and 2 are two bytes, 8 states, select mode 1 or 2, keep flags.
// - Decimal adjust corrects the accumulator to packed BCD in 4 states, keeps N.
`timescale 1ns/10ps
module ccd_core (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             cpu_halted,
    output logic             int_enable
);
    ccd_alu_if alu_if ();
    ccd_alu u_alu (.alu(alu_if));

    // Address map check
    function automatic logic mapped(input logic [7:0] ad);
        return (ad[1:0] == 2'b00) && ((ad <= ccd_pkg::OFF_WAKE)
               || ((ad >= ccd_pkg::OFF_REG_BASE) && (ad <= ccd_pkg::OFF_REG_LAST)));
    endfunction

    logic                aw_have, next_aw_have, w_have, next_w_have;
    logic [7:0]          aw_addr, next_aw_addr;
    logic [15:0]         w_data, next_w_data;
    logic [1:0]          w_strb, next_w_strb;
    logic                next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]          next_bresp, next_rresp;
    logic [31:0]         next_rdata;
    logic                do_wr, wr_err, issue, wake, busy;
    ccd_pkg::ccd_exec_e  state, next_state;
    logic [3:0]          tcnt, next_tcnt;
    logic                halt_pend, next_halt_pend, next_cpu_halted, next_int_enable;
    logic [7:0]          reg_file [8];
    logic [7:0]          next_reg_file [8];
    logic [7:0]          flags, next_flags, last_opc, next_last_opc, opc, acc;
    logic [15:0]         pc, next_pc;
    logic [1:0]          int_mode, next_int_mode;
    logic                pfx, next_pfx, bad, next_bad;
    ccd_pkg::ccd_kind_e  kind;
    logic [3:0]          run_t;
    logic [2:0]          dst;

    assign busy = (state == ccd_pkg::EX_BUSY);
    assign acc  = reg_file[ccd_pkg::ACC_IDX];
    assign opc  = w_data[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave next state
    always_comb
    begin
        next_aw_have = aw_have;
        next_aw_addr = aw_addr;
        next_w_have  = w_have;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        wr_err = !mapped(aw_addr)
              || ((aw_addr == ccd_pkg::OFF_OPCODE) && !(state == ccd_pkg::EX_IDLE));
        do_wr  = aw_have && w_have && !bvalid;
        if (awvalid && awready)
        begin
            next_aw_have = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_w_have = 1'b1;
            next_w_data = wdata[15:0];
            next_w_strb = wstrb[1:0];
        end
        if (bvalid && bready)
            next_bvalid = 1'b0;
        if (do_wr)
        begin
            next_aw_have = 1'b0;
            next_w_have  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_err ? ccd_pkg::RESP_SLVERR : ccd_pkg::RESP_OKAY;
        end
        if (rvalid && rready)
            next_rvalid = 1'b0;
        if (arvalid && arready)
        begin
            next_rvalid = 1'b1;
            next_rresp  = mapped(araddr) ? ccd_pkg::RESP_OKAY : ccd_pkg::RESP_SLVERR;
            case (araddr)
                ccd_pkg::OFF_OPCODE: next_rdata = {24'h00_0000, last_opc};
                ccd_pkg::OFF_FLAGS:  next_rdata = {24'h00_0000, flags};
                ccd_pkg::OFF_STATUS: next_rdata = {25'h000_0000, bad, pfx, int_mode, int_enable,
                                                   cpu_halted, busy};
                ccd_pkg::OFF_PC:     next_rdata = {16'h0000, pc};
                default: next_rdata = mapped(araddr) && araddr[5]
                                    ? {24'h00_0000, reg_file[araddr[4:2]]} : 32'h0000_0000;
            endcase
        end
        next_awready = !next_aw_have;
        next_wready  = !next_w_have;
        next_arready = !next_rvalid;
    end

    // Bus slave registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have <= 1'b0;
            aw_addr <= 8'h00;
            w_have  <= 1'b0;
            w_data  <= 16'h0000;
            w_strb  <= 2'b00;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= ccd_pkg::RESP_OKAY;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= ccd_pkg::RESP_OKAY;
        end
        else
        begin
            aw_have <= next_aw_have;
            aw_addr <= next_aw_addr;
            w_have  <= next_w_have;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            awready <= next_awready;
            wready  <= next_wready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Opcode decode and operand selection
    always_comb
    begin
        alu_if.op  = ccd_pkg::ALU_INC;
        alu_if.a   = acc;
        alu_if.fin = flags;
        kind  = ccd_pkg::K_BAD;
        run_t = pfx ? ccd_pkg::T_PFX_HALF : ccd_pkg::T_ONE_BYTE;
        dst   = ccd_pkg::ACC_IDX;
        if (pfx)
        begin
            case (opc)
                ccd_pkg::OPC_TWOS:
                begin
                    kind      = ccd_pkg::K_ALU;
                    alu_if.op = ccd_pkg::ALU_TWOS;
                end
                ccd_pkg::OPC_MODE0, ccd_pkg::OPC_MODE1, ccd_pkg::OPC_MODE2:
                    kind = ccd_pkg::K_MODE;
                default: kind = ccd_pkg::K_BAD;
            endcase
        end
        else if ((opc[7:6] == 2'b00) && ((opc[2:0] == ccd_pkg::FIELD_INC)
                                       || (opc[2:0] == ccd_pkg::FIELD_SUB1)))
        begin
            kind      = ccd_pkg::K_ALU;
            alu_if.op = opc[0] ? ccd_pkg::ALU_SUB1 : ccd_pkg::ALU_INC;
            alu_if.a  = reg_file[opc[5:3]];
            dst       = opc[5:3];
            if (opc[5:3] == ccd_pkg::MEM_IDX)
                run_t = ccd_pkg::T_INC_MEM;
        end
        else
        begin
            case (opc)
                // Accumulator and carry ops, picked by opcode bits 4:3
                ccd_pkg::OPC_DECIMAL, ccd_pkg::OPC_INVERT, ccd_pkg::OPC_CSET, ccd_pkg::OPC_CTOG:
                begin
                    kind      = ccd_pkg::K_ALU;
                    alu_if.op = opc[4] ? (opc[3] ? ccd_pkg::ALU_CTOG : ccd_pkg::ALU_CSET)
                                       : (opc[3] ? ccd_pkg::ALU_INVERT : ccd_pkg::ALU_DECIMAL);
                end
                ccd_pkg::OPC_IDLE:    kind = ccd_pkg::K_IDLE;
                ccd_pkg::OPC_HALT:    kind = ccd_pkg::K_HALT;
                ccd_pkg::OPC_INT_OFF: kind = ccd_pkg::K_IOFF;
                ccd_pkg::OPC_INT_ON:  kind = ccd_pkg::K_ION;
                ccd_pkg::OPC_PREFIX:  kind = ccd_pkg::K_PFX;
                default:              kind = ccd_pkg::K_BAD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Execute next state
    always_comb
    begin
        issue = do_wr && !wr_err && (aw_addr == ccd_pkg::OFF_OPCODE);
        wake  = do_wr && !wr_err && (aw_addr == ccd_pkg::OFF_WAKE) && w_data[0];
        next_state      = state;
        next_tcnt       = tcnt;
        next_halt_pend  = halt_pend && !wake;
        next_reg_file   = reg_file;
        next_flags      = flags;
        next_pc         = pc;
        next_int_enable = int_enable;
        next_int_mode   = int_mode;
        next_pfx        = pfx;
        next_bad        = bad;
        next_last_opc   = last_opc;
        case (state)
            ccd_pkg::EX_BUSY:
                if (tcnt == 4'h0)
                begin
                    next_state     = next_halt_pend ? ccd_pkg::EX_HALT : ccd_pkg::EX_IDLE;
                    next_halt_pend = 1'b0;
                end
                else
                    next_tcnt = tcnt - 4'h1;
            ccd_pkg::EX_HALT:
                if (wake)
                    next_state = ccd_pkg::EX_IDLE;
            ccd_pkg::EX_IDLE:
                next_state = ccd_pkg::EX_IDLE;
            default:
                next_state = ccd_pkg::EX_IDLE;
        endcase
        if (issue)
        begin
            next_state    = ccd_pkg::EX_BUSY;
            next_tcnt     = run_t - 4'h1;
            next_pc       = pc + 16'h0001;
            next_last_opc = opc;
            next_pfx      = (kind == ccd_pkg::K_PFX);
            next_bad      = (kind == ccd_pkg::K_BAD);
            case (kind)
                ccd_pkg::K_ALU:
                begin
                    next_reg_file[dst] = alu_if.res;
                    next_flags         = alu_if.fout;
                end
                ccd_pkg::K_HALT: next_halt_pend  = 1'b1;
                ccd_pkg::K_IOFF: next_int_enable = 1'b0;
                ccd_pkg::K_ION:  next_int_enable = 1'b1;
                ccd_pkg::K_MODE: next_int_mode = (opc == ccd_pkg::OPC_MODE1) ? 2'd1
                                               : (opc == ccd_pkg::OPC_MODE2) ? 2'd2 : 2'd0;
                default: next_pfx = next_pfx;
            endcase
        end
        else if (do_wr && !wr_err && w_strb[0])
        begin
            if (aw_addr == ccd_pkg::OFF_FLAGS)
                next_flags = w_data[7:0];
            else if (aw_addr == ccd_pkg::OFF_PC)
                next_pc[7:0] = w_data[7:0];
            else if (aw_addr[5])
                next_reg_file[aw_addr[4:2]] = w_data[7:0];
        end
        if (do_wr && !wr_err && (aw_addr == ccd_pkg::OFF_PC) && w_strb[1])
            next_pc[15:8] = w_data[15:8];
        next_cpu_halted = (next_state == ccd_pkg::EX_HALT);
    end

    // Execute registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state      <= ccd_pkg::EX_IDLE;
            tcnt       <= 4'h0;
            halt_pend  <= 1'b0;
            reg_file   <= '{default: 8'h00};
            flags      <= ccd_pkg::RST_FLAGS;
            pc         <= ccd_pkg::RST_PC;
            int_enable <= 1'b0;
            int_mode   <= ccd_pkg::RST_MODE;
            pfx        <= 1'b0;
            bad        <= 1'b0;
            last_opc   <= 8'h00;
            cpu_halted <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            tcnt       <= next_tcnt;
            halt_pend  <= next_halt_pend;
            reg_file   <= next_reg_file;
            flags      <= next_flags;
            pc         <= next_pc;
            int_enable <= next_int_enable;
            int_mode   <= next_int_mode;
            pfx        <= next_pfx;
            bad        <= next_bad;
            last_opc   <= next_last_opc;
            cpu_halted <= next_cpu_halted;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_four_states;
        busy [*4] ##1 !busy;
    endsequence
    sequence s_flags_kept;
        flags == $past(flags);
    endsequence

    a_inc_overflow: assert property (issue && !pfx && (opc == 8'h3C) && (acc == 8'h7F)
        |=> acc == 8'h80 && flags[ccd_pkg::FLG_PV] && !flags[ccd_pkg::FLG_N])
        else $error("increment overflow flag wrong");
    a_decimal_parity: assert property (issue && !pfx && (opc == ccd_pkg::OPC_DECIMAL)
        |=> flags[ccd_pkg::FLG_PV] == ~^acc
            && flags[ccd_pkg::FLG_N] == $past(flags[ccd_pkg::FLG_N]) ##0 s_four_states)
        else $error("decimal adjust parity or timing wrong");
    a_decrement_flags: assert property (issue && !pfx && (opc == 8'h3D)
        |=> acc == $past(acc) - 8'h01 && flags[ccd_pkg::FLG_N]
            && flags[ccd_pkg::FLG_C] == $past(flags[ccd_pkg::FLG_C]))
        else $error("decrement result or flags wrong");
    a_invert_acc: assert property (issue && !pfx && (opc == ccd_pkg::OPC_INVERT)
        |=> acc == ~$past(acc) && flags[ccd_pkg::FLG_H] && flags[ccd_pkg::FLG_N] ##0 s_four_states)
        else $error("invert result, flags or timing wrong");
    a_twos_acc: assert property (issue && pfx && (opc == ccd_pkg::OPC_TWOS)
        |=> acc == 8'h00 - $past(acc) && flags[ccd_pkg::FLG_N]
            && flags[ccd_pkg::FLG_PV] == ($past(acc) == 8'h80) ##0 s_four_states)
        else $error("negate result or flags wrong");
    a_prefix_half: assert property (issue && !pfx && (opc == ccd_pkg::OPC_PREFIX)
        |=> pfx ##0 s_flags_kept ##0 s_four_states)
        else $error("prefix byte timing wrong");
    a_int_latch: assert property (issue && !pfx && ((opc == ccd_pkg::OPC_INT_OFF)
        || (opc == ccd_pkg::OPC_INT_ON)) |=> int_enable == $past(opc[3]) ##0 s_flags_kept)
        else $error("interrupt enable latch wrong");
    a_carry_ops: assert property (issue && !pfx && (opc == ccd_pkg::OPC_CSET
        || opc == ccd_pkg::OPC_CTOG) |=> !flags[ccd_pkg::FLG_N] && flags[ccd_pkg::FLG_C]
            == ($past(opc[3]) ? !$past(flags[ccd_pkg::FLG_C]) : 1'b1))
        else $error("carry set or toggle wrong");
    a_mode_zero: assert property (issue && pfx && (opc == ccd_pkg::OPC_MODE0)
        |=> int_mode == 2'd0 ##0 s_flags_kept ##0 s_four_states)
        else $error("mode 0 select wrong");
    a_mode_high: assert property (issue && pfx && (opc == ccd_pkg::OPC_MODE2)
        |=> int_mode == 2'd2 ##0 s_flags_kept)
        else $error("mode 2 select wrong");
    a_idle_pc: assert property (issue && !pfx && (opc == ccd_pkg::OPC_IDLE)
        |=> pc == $past(pc) + 16'h0001 ##0 s_flags_kept ##0 s_four_states)
        else $error("idle opcode effect wrong");
    a_halt_hold: assert property (cpu_halted && !wake |=> cpu_halted && !issue)
        else $error("halt left without wake");
endmodule

/* File: ccd_prog_mem.sv */
// Program memory model: opcode bytes fed to the core in index order.
// Assumes the bench steps the index once per issued byte.
`timescale 1ns/10ps
module ccd_prog_mem (
    input  wire logic [4:0] idx,
    output logic      [7:0] op
);
    // Program bytes; prefix bytes precede each two-byte opcode
    logic [7:0] rom [18] = '{8'h3C, 8'h3D, 8'h2F, 8'h37, 8'h3F, 8'hED, 8'h44, 8'h00, 8'hFB,
                             8'hF3, 8'hED, 8'h5E, 8'hED, 8'h56, 8'hED, 8'h46, 8'h27, 8'h76};
    assign op = rom[idx];
endmodule

/* File: ccd_core_tb.sv */
// Testbench for the decode core: runs a short program over the register bus.
// Assumes ccd_pkg, ccd_alu_if, ccd_alu, ccd_core and ccd_prog_mem compiled first.
`timescale 1ns/10ps
module ccd_core_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, op;
    logic [31:0] wdata = 32'h0000_0000, rdata, st, ac, fl, pc;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, cpu_halted, int_enable;
    logic [1:0]  bresp, rresp, rs;
    logic [4:0]  idx = 5'h00;
    // Expected {latch, mode, accumulator, flags} after each program byte before the final halt byte
    logic [19:0] exp_t [17] = '{20'h0_8094, 20'h0_7F16, 20'h0_8016, 20'h0_8005, 20'h0_8014,
        20'h0_8014, 20'h0_8087, 20'h0_8087, 20'h4_8087, 20'h0_8087, 20'h0_8087, 20'h2_8087,
        20'h2_8087, 20'h1_8087, 20'h1_8087, 20'h0_8087, 20'h0_2003};
    int          miscompares = 0, comparisons = 0;

    always #20 aclk = ~aclk;

    ccd_core ccd_core_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cpu_halted(cpu_halted), .int_enable(int_enable));
    ccd_prog_mem ccd_prog_mem_inst (.idx(idx), .op(op));

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic end_sim;
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Compare seen with expected, count both
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Bus write: address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        r = bresp;
        if (n == 50) begin miscompares++; end_sim; end
    endtask
    // Bus read: address held until taken, data kept at the answer
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        if (n == 50) begin miscompares++; end_sim; end
    endtask
    // Poll status until the core is no longer busy
    task automatic idle;
        for (int n = 0; n < 50; n++)
        begin
            rd(8'h08, st, rs);
            if (st[0] === 1'b0) return;
        end
        miscompares++;
        end_sim;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: program run, halt and wake, refusals
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h04, fl, rs);
        chk(fl, 32'h0000_0000);
        wr(8'h3C, 32'h0000_007F, rs);
        for (int i = 0; i < 18; i++)
        begin
            idx = i[4:0];
            #1;
            wr(8'h00, {24'h00_0000, op}, rs);
            chk({30'h0000_0000, rs}, 32'h0000_0000);
            idle;
            if (i == 17) break;
            rd(8'h3C, ac, rs);
            rd(8'h04, fl, rs);
            chk({16'h0000, ac[7:0], fl[7:0]},
                {16'h0000, exp_t[i][15:0]});
            chk({29'h0000_0000, int_enable, st[4:3]},
                {28'h000_0000, exp_t[i][19:16]});
        end
        chk({31'h0, cpu_halted}, 32'h0000_0001);
        wr(8'h00, 32'h0000_0000, rs);
        chk({30'h0000_0000, rs}, 32'h0000_0002);
        rd(8'h0C, pc, rs);
        chk(pc, 32'h0000_0012);
        wr(8'h10, 32'h0000_0001, rs);
        rd(8'h08, st, rs);
        chk({31'h0, st[1]}, 32'h0000_0000);
        rd(8'h14, ac, rs);
        chk({ac[29:0], rs}, 32'h0000_0002);
        end_sim;
    end
endmodule
